//--- design/udefc_pkg.sv
package udefc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned BAUD_DEF      = 115_200;
  // Cycles per bit at the default baud, rounded down, never below one
  localparam int unsigned BIT_CYC_DEF   = (CLK_HZ / BAUD_DEF) < 1 ? 1 : (CLK_HZ / BAUD_DEF);
  localparam int unsigned DIV_W         = 16;
  localparam int unsigned CTS_SETTLE    = 2;   // System-clock periods from clear-to-send fall
  localparam int unsigned FIFO_DEPTH    = 4;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned CNT_W         = 4;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam logic [3:0] DATA_BITS      = 4'h8;
  localparam logic [3:0] STOP_BITS_ONE  = 4'h1;
  localparam logic [3:0] STOP_BITS_TWO  = 4'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                  de_active_low;
    logic                  cts_en;
    logic                  two_stop;
    logic [DIV_W-1:0]      bit_cyc;
  } udefc_cfg_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_WAIT  = 3'b001,
    ST_LEAD  = 3'b010,
    ST_START = 3'b011,
    ST_DATA  = 3'b100,
    ST_STOP  = 3'b101,
    ST_TAIL  = 3'b110
  } udefc_state_t;

endpackage : udefc_pkg

//--- design/udefc_fifo.sv
`timescale 1ns/100ps
module udefc_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             in_ready_q;
  logic [WIDTH-1:0] rdat_q;
  logic             push;
  logic             pop;
  logic [AW-1:0]    rd_nx;

  // Ready is registered from the next count, so the write port sees a flop
  assign in_ready  = in_ready_q;
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready_q;
  assign cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  assign pop       = out_valid && out_ready;
  assign rd_nx     = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
  // Registered read port; it tracks the head entry, refreshed on pop or on first write
  assign out_data  = rdat_q;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_q   <= '0;
      rd_q   <= '0;
      cnt_q  <= '0;
      in_ready_q <= 1'b1;
      rdat_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_nx;
      end
      cnt_q <= cnt_d;
      in_ready_q <= (cnt_d != (AW+1)'(DEPTH));
      if (push && (cnt_q == '0 || (pop && cnt_q == (AW+1)'(1)))) begin
        rdat_q <= in_data;
      end else if (pop) begin
        rdat_q <= mem_q[rd_nx];
      end
    end
  end

endmodule : udefc_fifo

//--- design/udefc_tx.sv
`timescale 1ns/100ps
// How it works
// [R1] Driver-enable pin polarity is set by a config bit; active low drives it low.
// [R2] With flow control and data loaded, enable asserts on the third clock edge after clear-to-send falls.
// [R3] Start bit falls one bit period after enable asserts, within one extra clock.
// [R4] Enable releases one clock after the last stop bit ends.
// [R5] Without flow control, a data write alone leads to enable assertion.
// [R6] Enable stays asserted if the next byte is queued before the current one ends and clear-to-send permits it.
// [R7] With flow control on, nothing starts while clear-to-send stays high.
module udefc_tx (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       nrst,
  // Configuration
  input  wire udefc_pkg::udefc_cfg_t      cfg,
  // Transmit data write port
  input  wire logic                       wr_valid,
  output logic                            wr_ready,
  input  wire logic [udefc_pkg::DATA_W-1:0] wr_data,
  // Line side
  input  wire logic                       cts_n,
  output logic                            txd,
  output logic                            de_pin,
  // Status
  output logic                            busy
);

  // ----------------------------------------------------------------
  // Input synchroniser and queue
  // ----------------------------------------------------------------
  // Only the second stage is read by logic
  logic       cts_m_q;
  logic       cts_s_q;
  logic       q_valid;
  logic       q_pop;
  logic [udefc_pkg::DATA_W-1:0] q_data;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      // Idle high, so release never looks like clear-to-send
      cts_m_q <= 1'b1;
      cts_s_q <= 1'b1;
    end else begin
      cts_m_q <= cts_n;
      cts_s_q <= cts_m_q;
    end
  end

  udefc_fifo #(
    .WIDTH (udefc_pkg::DATA_W),
    .DEPTH (udefc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (q_valid),
    .out_ready (q_pop),
    .out_data  (q_data)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  udefc_pkg::udefc_state_t st_q;
  udefc_pkg::udefc_state_t st_d;
  logic [udefc_pkg::DIV_W-1:0] bcnt_q;
  logic [udefc_pkg::DIV_W-1:0] bcnt_d;
  logic [udefc_pkg::CNT_W-1:0] nbit_q;
  logic [udefc_pkg::CNT_W-1:0] nbit_d;
  logic [udefc_pkg::DATA_W-1:0] sh_q;
  logic [udefc_pkg::DATA_W-1:0] sh_d;
  logic       de_q;
  logic       de_d;
  logic       txd_q;
  logic       txd_d;
  logic       busy_q;
  logic       bit_end;
  logic       cts_ok;
  logic       go_ok;
  logic       last_data;
  logic       last_stop;
  logic [udefc_pkg::DATA_W-1:0] sh_src;
  logic [udefc_pkg::DATA_W-1:0] sh_nx;
  logic [udefc_pkg::CNT_W-1:0] stop_n;
  logic [udefc_pkg::DIV_W-1:0] bit_len;

  // Bit length of zero would stall; treat it as one cycle
  assign bit_len   = (cfg.bit_cyc == '0) ? udefc_pkg::DIV_W'(1) : cfg.bit_cyc;
  assign bit_end   = (bcnt_q == bit_len - udefc_pkg::DIV_W'(1));
  assign cts_ok    = !cfg.cts_en || !cts_s_q;                              // [R7]
  assign go_ok     = q_valid && cts_ok;                                    // [R7]
  assign stop_n    = cfg.two_stop ? udefc_pkg::STOP_BITS_TWO : udefc_pkg::STOP_BITS_ONE;
  assign last_data = (nbit_q == udefc_pkg::DATA_BITS - 4'h1);
  assign last_stop = (nbit_q == stop_n - 4'h1);
  // Head leaves the queue in the first cycle of the start bit
  assign q_pop     = (st_q == udefc_pkg::ST_START) && (bcnt_q == '0);
  // A one-cycle bit ends in the pop cycle, so shift straight from the queue head
  assign sh_src    = q_pop ? q_data : sh_q;
  assign sh_nx     = {1'b0, sh_src[udefc_pkg::DATA_W-1:1]};

  always_comb begin
    st_d   = st_q;
    bcnt_d = bit_end ? '0 : bcnt_q + udefc_pkg::DIV_W'(1);
    nbit_d = nbit_q;
    sh_d   = sh_q;
    de_d   = de_q;
    txd_d  = txd_q;
    unique case (st_q)
      udefc_pkg::ST_IDLE: begin
        bcnt_d = '0;
        if (go_ok) begin
          // Synchroniser already spent two clocks after the pin fell
          st_d = udefc_pkg::ST_LEAD;                                         // [R2] [R5]
          de_d = 1'b1;
        end
      end
      udefc_pkg::ST_WAIT: begin
        // Unused holding state kept for a clean encoding
        bcnt_d = '0;
        st_d   = udefc_pkg::ST_IDLE;
      end
      udefc_pkg::ST_LEAD: begin
        // Line held high one bit while the transceiver turns on
        if (bit_end) begin
          st_d  = udefc_pkg::ST_START;                                      // [R3]
          txd_d = 1'b0;
        end
      end
      udefc_pkg::ST_START: begin
        sh_d = sh_src;
        if (bit_end) begin
          st_d   = udefc_pkg::ST_DATA;
          nbit_d = '0;
          txd_d  = sh_src[0];
          sh_d   = sh_nx;
        end
      end
      udefc_pkg::ST_DATA: begin
        // Least significant bit leaves first
        if (bit_end) begin
          if (last_data) begin
            st_d   = udefc_pkg::ST_STOP;
            nbit_d = '0;
            txd_d  = 1'b1;
          end else begin
            nbit_d = nbit_q + 4'h1;
            txd_d  = sh_src[0];
            sh_d   = sh_nx;
          end
        end
      end
      udefc_pkg::ST_STOP: begin
        if (bit_end) begin
          if (last_stop) begin
            // Next byte queued: start bit follows at once and enable stays on
            if (go_ok) begin
              st_d  = udefc_pkg::ST_START;                                  // [R6]
              txd_d = 1'b0;
            end else begin
              st_d = udefc_pkg::ST_TAIL;
            end
          end else begin
            nbit_d = nbit_q + 4'h1;
          end
        end
      end
      udefc_pkg::ST_TAIL: begin
        // One clock after the stop bit ends, enable drops
        de_d   = 1'b0;                                                      // [R4]
        bcnt_d = '0;
        st_d   = udefc_pkg::ST_IDLE;
      end
      default: begin
        // Illegal code: back to idle with the line released
        st_d   = udefc_pkg::ST_IDLE;
        de_d   = 1'b0;
        txd_d  = 1'b1;
        bcnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q   <= udefc_pkg::ST_IDLE;
      bcnt_q <= '0;
      nbit_q <= '0;
      sh_q   <= '0;
      de_q   <= 1'b0;
      txd_q  <= 1'b1;
      busy_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      bcnt_q <= bcnt_d;
      nbit_q <= nbit_d;
      sh_q   <= sh_d;
      de_q   <= de_d;
      txd_q  <= txd_d;
      // Follows the next state so it rises with the enable
      busy_q <= (st_d != udefc_pkg::ST_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  logic de_pin_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      // Inactive level in reset, so the transceiver never drives while held
      de_pin_q <= cfg.de_active_low;                                        // [R1]
    end else begin
      de_pin_q <= de_d ^ cfg.de_active_low;                                 // [R1]
    end
  end

  assign de_pin = de_pin_q;
  assign txd    = txd_q;
  assign busy   = busy_q;

endmodule : udefc_tx

//--- test/udefc_line_model.sv
`timescale 1ns/100ps
// Transceiver plus remote peer; sampling is mid-bit, so one clock of skew is harmless
module udefc_line_model (
  input  wire logic        clk,
  input  wire logic        txd,
  input  wire logic        de_on,
  input  wire logic [15:0] bit_cyc,
  input  wire logic        hold,
  output logic             cts_n,
  output logic [7:0]       rx_byte,
  output int               rx_cnt,
  output int               rx_bad
);
  wire logic line;
  // Bias holds the bus high whenever the driver is off
  assign line  = de_on ? txd : 1'b1;
  assign cts_n = hold;
  initial begin
    rx_cnt = 0;
    rx_bad = 0;
    rx_byte = 8'h00;
    forever begin
      @(negedge line);
      repeat (bit_cyc / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_cyc) @(posedge clk);
        rx_byte[i] = line;
      end
      repeat (bit_cyc) @(posedge clk);
      // Stop bit high and line still driven
      if (line !== 1'b1 || de_on !== 1'b1) rx_bad++;
      rx_cnt++;
    end
  end
endmodule : udefc_line_model

//--- test/udefc_tx_asserts.sv
`timescale 1ns/100ps
module udefc_tx_asserts (
  // Clock and reset
  input wire logic                         clk,
  input wire logic                         nrst,
  // Block ports
  input wire udefc_pkg::udefc_cfg_t        cfg,
  input wire logic                         wr_valid,
  input wire logic                         wr_ready,
  input wire logic [udefc_pkg::DATA_W-1:0] wr_data,
  input wire logic                         cts_n,
  input wire logic                         txd,
  input wire logic                         de_pin,
  input wire logic                         busy
);
  wire         de_act = de_pin ^ cfg.de_active_low;
  logic        prev_q;
  logic        lead_q;
  logic [16:0] cnt_q;
  // Tracked through reset too, so release never looks like a rising enable
  always_ff @(posedge clk) begin
    prev_q <= de_act;
    if (!nrst) begin
      lead_q <= 1'b0;
    end else if (de_act && !prev_q) begin
      lead_q <= 1'b1;
      cnt_q <= 17'h00001;
    end else if (!txd) begin
      lead_q <= 1'b0;
    end else if (lead_q) begin
      cnt_q <= cnt_q + 17'h00001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence cts_fall_s;
    cfg.cts_en && cts_n && !de_act ##1 !cts_n;
  endsequence
  idle_line_a: assert property (!busy |-> txd) else $error("line low while idle");
  lead_time_a: assert property (lead_q && !txd |-> cnt_q >= {1'b0, cfg.bit_cyc} &&
    cnt_q <= {1'b0, cfg.bit_cyc} + 17'h00001) else $error("lead-in length wrong");
  low_drive_a: assert property (!txd |-> de_act) else $error("line low, driver off");
  cts_hold_a: assert property (cfg.cts_en && !de_act && cts_n && $past(cts_n)
    |=> !de_act) else $error("enable without clear-to-send");
  cts_min_a: assert property (cts_fall_s |-> !de_act ##1 !de_act)
    else $error("enable too soon after clear-to-send");
  de_release_a: assert property ($fell(de_act) |-> $past(txd) && $past(txd, 2))
    else $error("enable released too early");
  start_width_a: assert property ($fell(txd) && cfg.bit_cyc > 16'h0001 |=> !txd)
    else $error("start bit too short");
  wr_answer_a: assert property (!cfg.cts_en && !busy && !de_act && wr_valid && wr_ready
    |-> ##[1:3] de_act) else $error("no enable after write");
  de_level_a: assert property ((!busy && !wr_valid) [*3] |-> de_pin == cfg.de_active_low)
    else $error("idle enable level wrong");
endmodule : udefc_tx_asserts
bind udefc_tx udefc_tx_asserts u_chk (.clk(clk), .nrst(nrst), .cfg(cfg), .wr_valid(wr_valid),
  .wr_ready(wr_ready), .wr_data(wr_data), .cts_n(cts_n), .txd(txd), .de_pin(de_pin), .busy(busy));

//--- test/uart_driver_enable_flow_ctl_tb.sv
`timescale 1ns/100ps
module uart_driver_enable_flow_ctl_tb;
  logic                  clk, nrst, wr_valid, hold;
  logic [7:0]            wr_data, rx_byte;
  udefc_pkg::udefc_cfg_t cfg;
  wire logic             wr_ready, cts_n, txd, de_pin, busy;
  int                    rx_cnt, rx_bad, num_errors, n_compared;
  wire logic             de_on = de_pin ^ cfg.de_active_low;
  udefc_tx uut (.clk(clk), .nrst(nrst), .cfg(cfg), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .cts_n(cts_n), .txd(txd), .de_pin(de_pin), .busy(busy));
  udefc_line_model peer (.clk(clk), .txd(txd), .de_on(de_on), .bit_cyc(cfg.bit_cyc),
    .hold(hold), .cts_n(cts_n), .rx_byte(rx_byte), .rx_cnt(rx_cnt), .rx_bad(rx_bad));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Drive and sample at one offset after the edge, when registered outputs have settled
  task step;
    @(posedge clk);
    #2;
  endtask : step
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task chk_rng(input string nm, input int lo, input int hi, input int g);
    n_compared++;
    if (g < lo || g > hi) begin
      num_errors++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_rng
  task end_sim;
    $display("errors %0d compares %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task rst(input logic lo, input logic ce, input logic two);
    nrst = 1'b0;
    cfg = '{lo, ce, two, 16'h0008};
    hold = ce;
    repeat (8) step;
    chk("rst_de", {7'h00, lo}, {7'h00, de_pin});
    nrst = 1'b1;
    repeat (3) step;
    chk("idle_de", {7'h00, lo}, {7'h00, de_pin});
    chk("idle_busy", 8'h00, {7'h00, busy});
  endtask : rst
  // Leaves the request up so back-to-back writes never toggle it in one time step
  task wr(input logic [7:0] b);
    wr_valid = 1'b1;
    wr_data = b;
    while (wr_ready !== 1'b1) step;
    step;
  endtask : wr
  task xfer(input logic [7:0] b, input int nb, input logic ce);
    int n;
    wr(b);
    wr_valid = 1'b0;
    if (ce) begin
      repeat (40) step;
      chk("held_de", 8'h00, {7'h00, de_on});
      chk("held_busy", 8'h00, {7'h00, busy});
      hold = 1'b0;
    end
    n = 0;
    while (de_on !== 1'b1 && n < 500) begin step; n++; end
    chk_rng("de_lead", ce ? 2 : 1, ce ? 10 : 3, n);
    chk("lead_busy", 8'h01, {7'h00, busy});
    n = 0;
    while (txd !== 1'b0 && n < 500) begin step; n++; end
    chk_rng("lead_in", 8, 9, n);
    n = 0;
    while (de_on !== 1'b0 && n < 2000) begin step; n++; end
    chk_rng("tail", (9 + nb) * 8 + 1, (9 + nb) * 8 + 2, n);
    chk("tail_busy", 8'h00, {7'h00, busy});
    chk("rx_byte", b, rx_byte);
    hold = ce;
  endtask : xfer
  task t_plain;
    rst(1'b0, 1'b0, 1'b0);
    xfer(8'hA5, 1, 1'b0);
    $display("plain write test done");
  endtask : t_plain
  task t_cts;
    rst(1'b0, 1'b1, 1'b1);
    xfer(8'hC3, 2, 1'b1);
    $display("clear-to-send test done");
  endtask : t_cts
  task t_b2b;
    int k, m, n;
    rst(1'b1, 1'b0, 1'b0);
    k = rx_cnt;
    for (int i = 0; i < 5; i++) wr(8'h30 + 8'(i));
    wr_valid = 1'b0;
    repeat (3) step;
    chk("full", 8'h00, {7'h00, wr_ready});
    m = 0;
    n = 0;
    while (rx_cnt < k + 5 && m < 3000) begin
      step;
      m++;
      if (de_on !== 1'b1) n++;
    end
    chk_rng("de_gaps", 0, 0, n);
    chk("last", 8'h34, rx_byte);
    chk("bad", 8'h00, 8'(rx_bad));
    $display("back-to-back test done");
  endtask : t_b2b
  initial begin
    num_errors = 0;
    n_compared = 0;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    t_plain;
    t_cts;
    t_b2b;
    end_sim;
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_sim;
  end
endmodule : uart_driver_enable_flow_ctl_tb
